// ### lfl_frame_low_detect.sv
// Overview of operation
// - A read-only mirror shows each channel's low-detect flag, channels 0 to 3.
// - While any mirror bit is 1, low detection raises no further interrupt.
// - With detection enabled, a falling receive edge sets the flag and requests.
// - Enabling detection while the receive line is low sets the flag at once.
// - Hardware never clears status flags; at the status register writing 0 clears, at the clear register writing 1 clears.
// - A set low-detect flag blocks new requests from every channel, itself included.
// - Break low lasts 13 to 28 bit times, chosen by a four-bit field.
// - Break delimiter lasts 1 to 4 bit times, chosen by a two-bit field.
// - Send the response bytes with an interbyte space between them; an error ends the frame.
// - Receive bytes on start bits; an error aborts without checksum judgement.
// - Interrupt requested while an enabled status flag is 1; sources are aggregated.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module lfl_frame_low_detect (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        cen,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // LIN transceiver
  input  wire logic [3:0]  bus_receive_pin,
  output logic             bus_transmit_pin,
  // Interrupt
  output logic             irq
);
  typedef struct packed {
    lfl_pkg::lfl_phase_t   phase;
    logic [3:0]            low_detect_enable;
    lfl_pkg::lfl_frame_cfg_t cfg;
    logic [6:0]            status;
    logic [6:0]            ien;
    logic [15:0]           baud;
    logic [63:0]           txd;
    logic [63:0]           rxd;
    logic [15:0]           tmr;
    logic [4:0]            bits;
    logic [3:0]            idx;
    logic                  tx_go;
    logic                  tx_pin;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } lfl_top_st_t;

  localparam lfl_top_st_t TOP_RST = '{phase: lfl_pkg::P_IDLE,
                                      low_detect_enable: lfl_pkg::MODE_RST,
                                      ien: lfl_pkg::IEN_RST, baud: lfl_pkg::BAUD_RST,
                                      tx_pin: 1'b1, default: '0};

  lfl_top_st_t q;
  lfl_top_st_t d;
  logic [3:0]  ld_ev;
  logic [3:0]  rx_lvl;
  logic        eng_tx;
  logic        eng_tx_done;
  logic        eng_rx_done;
  logic [7:0]  eng_rx_byte;
  logic        eng_err;
  logic        acc_wr;
  logic        bit_end;
  logic        busy;
  logic [3:0]  cnt_eff;
  logic [5:0]  byte_sel;
  logic [6:0]  st_set;

  // ----------------------------------------------------------------
  // Per-channel low detection
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++)
  begin : g_chan
    lfl_low_detect u_ld (
      .ref_clk     (ref_clk),
      .srst        (srst),
      .cen         (cen),
      .rx_pin      (bus_receive_pin[g]),
      .enable      (q.low_detect_enable[g]),
      .event_pulse (ld_ev[g]),
      .rx_level    (rx_lvl[g])
    );
  end

  // ----------------------------------------------------------------
  // Byte engine for channel 0
  // ----------------------------------------------------------------
  lfl_byte_engine u_eng (
    .ref_clk (ref_clk),
    .srst    (srst),
    .cen     (cen),
    .baud    (q.baud),
    .tx_go   (q.tx_go),
    .tx_byte (q.txd[byte_sel +: 8]),
    .tx_pin  (eng_tx),
    .tx_done (eng_tx_done),
    .rx_arm  (q.phase == lfl_pkg::P_RX_BYTE),
    .rx_in   (rx_lvl[0]),
    .rx_done (eng_rx_done),
    .rx_byte (eng_rx_byte),
    .err     (eng_err)
  );

  // ----------------------------------------------------------------
  // Registers, frame sequencer and interrupt
  // ----------------------------------------------------------------
  // Next state of the whole block
  always_comb
  begin
    d = q;
    d.tx_go = 1'b0;
    d.pready = 1'b0;
    st_set = 7'h00;
    byte_sel = {q.idx[2:0], 3'b000};
    busy = q.phase != lfl_pkg::P_IDLE;
    acc_wr = psel && penable && pwrite && q.pready;
    bit_end = q.tmr >= q.baud - 16'h0001;
    cnt_eff = (q.cfg.response_byte_count > lfl_pkg::MAX_BYTES) ? lfl_pkg::MAX_BYTES
                                                                : q.cfg.response_byte_count;
    // Setup cycle: latch read data, answer in the access cycle
    if (psel && !penable)
    begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      case (paddr)
        lfl_pkg::OFF_MODE:   d.prdata[3:0] = q.low_detect_enable;
        lfl_pkg::OFF_FRAME:  d.prdata[15:0] = q.cfg;
        lfl_pkg::OFF_STATUS: d.prdata[7:0] = {busy, q.status};
        lfl_pkg::OFF_CLEAR:  d.prdata[0] = 1'b0;
        lfl_pkg::OFF_IEN:    d.prdata[6:0] = q.ien;
        lfl_pkg::OFF_MIRROR: d.prdata[3:0] = q.status[3:0];
        lfl_pkg::OFF_BAUD:   d.prdata[15:0] = q.baud;
        lfl_pkg::OFF_CMD:    d.prdata[0] = busy;
        lfl_pkg::OFF_TXD0:   d.prdata = q.txd[31:0];
        lfl_pkg::OFF_TXD1:   d.prdata = q.txd[63:32];
        lfl_pkg::OFF_RXD0:   d.prdata = q.rxd[31:0];
        lfl_pkg::OFF_RXD1:   d.prdata = q.rxd[63:32];
        default:             d.pslverr = 1'b1;
      endcase
    end
    // Frame sequencer
    if (q.phase == lfl_pkg::P_BRK_LOW || q.phase == lfl_pkg::P_BRK_DELIM
        || q.phase == lfl_pkg::P_TX_GAP)
    begin
      d.tmr = bit_end ? 16'h0000 : q.tmr + 16'h0001;
      d.bits = bit_end ? q.bits + 5'h01 : q.bits;
    end
    unique case (q.phase)
      lfl_pkg::P_IDLE:
        d.tx_pin = 1'b1;
      lfl_pkg::P_BRK_LOW:
      begin
        d.tx_pin = 1'b0;
        if (bit_end && q.bits == lfl_pkg::BRK_LOW_BASE
            + {1'b0, q.cfg.break_low_length} - 5'h01)
        begin
          d.phase = lfl_pkg::P_BRK_DELIM;
          d.bits = 5'h00;
          d.tx_pin = 1'b1;
        end
      end
      lfl_pkg::P_BRK_DELIM:
        if (bit_end && q.bits == lfl_pkg::BRK_DELIM_BASE
            + {3'b000, q.cfg.break_delimiter_length} - 5'h01)
        begin
          d.idx = 4'h0;
          d.phase = (cnt_eff == 4'h0) ? lfl_pkg::P_IDLE : lfl_pkg::P_TX_BYTE;
          d.tx_go = cnt_eff != 4'h0;
          st_set[lfl_pkg::ST_TXDONE] = cnt_eff == 4'h0;
        end
      lfl_pkg::P_TX_BYTE:
      begin
        d.tx_pin = eng_tx;
        if (eng_err)
        begin
          st_set[lfl_pkg::ST_ERR] = 1'b1;
          d.phase = lfl_pkg::P_IDLE;
          d.tx_pin = 1'b1;
        end
        else if (eng_tx_done)
        begin
          d.idx = q.idx + 4'h1;
          d.tmr = 16'h0000;
          d.bits = 5'h00;
          if (q.idx + 4'h1 == cnt_eff)
          begin
            st_set[lfl_pkg::ST_TXDONE] = 1'b1;
            d.phase = lfl_pkg::P_IDLE;
          end
          else if (q.cfg.gap_len == 2'b00)
            d.tx_go = 1'b1;
          else
            d.phase = lfl_pkg::P_TX_GAP;
        end
      end
      lfl_pkg::P_TX_GAP:
      begin
        d.tx_pin = 1'b1;
        if (bit_end && q.bits == {3'b000, q.cfg.gap_len} - 5'h01)
        begin
          d.phase = lfl_pkg::P_TX_BYTE;
          d.tx_go = 1'b1;
        end
      end
      lfl_pkg::P_RX_BYTE:
        if (eng_err)
        begin
          st_set[lfl_pkg::ST_ERR] = 1'b1;
          d.phase = lfl_pkg::P_IDLE;
        end
        else if (eng_rx_done)
        begin
          d.rxd[byte_sel +: 8] = eng_rx_byte;
          d.idx = q.idx + 4'h1;
          if (q.idx + 4'h1 == cnt_eff)
          begin
            st_set[lfl_pkg::ST_RXDONE] = 1'b1;
            d.phase = lfl_pkg::P_IDLE;
          end
        end
    endcase
    // Access cycle: writes take effect when pready is seen
    if (acc_wr)
    begin
      case (paddr)
        lfl_pkg::OFF_MODE:   d.low_detect_enable = pwdata[3:0];
        lfl_pkg::OFF_FRAME:  d.cfg = pwdata[15:0];
        lfl_pkg::OFF_STATUS: d.status = d.status & pwdata[6:0];
        lfl_pkg::OFF_CLEAR:  d.status = d.status & ~pwdata[6:0];
        lfl_pkg::OFF_IEN:    d.ien = pwdata[6:0];
        lfl_pkg::OFF_BAUD:   d.baud = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        lfl_pkg::OFF_TXD0:   d.txd[31:0] = pwdata;
        lfl_pkg::OFF_TXD1:   d.txd[63:32] = pwdata;
        lfl_pkg::OFF_CMD:
          if (!busy && pwdata[lfl_pkg::CMD_SEND])
          begin
            d.phase = lfl_pkg::P_BRK_LOW;
            d.tmr = 16'h0000;
            d.bits = 5'h00;
            d.tx_pin = 1'b0;
          end
          else if (!busy && pwdata[lfl_pkg::CMD_RECV])
          begin
            d.idx = 4'h0;
            d.phase = (cnt_eff == 4'h0) ? lfl_pkg::P_IDLE : lfl_pkg::P_RX_BYTE;
            st_set[lfl_pkg::ST_RXDONE] = cnt_eff == 4'h0;
          end
        default: ;
      endcase
    end
    // Frame flags set by hardware beat a software clear in the same cycle
    d.status = d.status | st_set;
    // Low-detect flags set only while none is set; a set beats a clear
    d.status[3:0] = d.status[3:0] | (ld_ev & {4{~|q.status[3:0]}});
    d.irq = |(q.status & q.ien);
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      q <= TOP_RST;
    else if (cen)
      q <= d;
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign bus_transmit_pin = q.tx_pin;
  assign irq              = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned ph_cyc;
  logic        clr_wr;

  assign clr_wr = acc_wr && (paddr == lfl_pkg::OFF_STATUS || paddr == lfl_pkg::OFF_CLEAR);

  // Cycles spent in the current phase
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ph_cyc <= 0;
    else if (cen)
      ph_cyc <= (d.phase != q.phase) ? 0 : ph_cyc + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_mirror_read: assert property (
    cen && psel && !penable && paddr == lfl_pkg::OFF_MIRROR
    |=> prdata[3:0] == $past(q.status[3:0])) else $error("mirror differs from flags");
  a_low_gate: assert property (
    cen && (|q.status[3:0]) |=> (q.status[3:0] & ~$past(q.status[3:0])) == 4'h0)
    else $error("new low flag while one set");
  a_low_set: assert property (
    cen && q.status[3:0] == 4'h0 |=> (q.status[3:0] & $past(ld_ev)) == $past(ld_ev))
    else $error("low flag not set");
  a_no_self_clr: assert property (
    ($past(q.status) & ~q.status) != 7'h00 |-> $past(clr_wr && cen))
    else $error("status cleared by hardware");
  a_break_low: assert property (
    cen && q.phase == lfl_pkg::P_BRK_LOW && d.phase == lfl_pkg::P_BRK_DELIM
    |-> ph_cyc + 1 == (32'(q.cfg.break_low_length) + 32'(lfl_pkg::BRK_LOW_BASE))
        * 32'(q.baud)) else $error("break low length wrong");
  a_break_delim: assert property (
    cen && q.phase == lfl_pkg::P_BRK_DELIM && d.phase != lfl_pkg::P_BRK_DELIM
    |-> ph_cyc + 1 == (32'(q.cfg.break_delimiter_length) + 32'(lfl_pkg::BRK_DELIM_BASE))
        * 32'(q.baud)) else $error("delimiter length wrong");
  a_tx_count: assert property (
    $rose(q.status[lfl_pkg::ST_TXDONE]) |-> q.idx == cnt_eff) else $error("byte count wrong");
  a_rx_abort: assert property (
    cen && q.phase == lfl_pkg::P_RX_BYTE && eng_err
    |=> q.phase == lfl_pkg::P_IDLE && q.status[lfl_pkg::ST_ERR]) else $error("rx not aborted");
  a_irq_level: assert property (
    cen |=> irq == |($past(q.status) & $past(q.ien))) else $error("interrupt level wrong");
  a_bit_timer: assert property (
    q.tmr < q.baud) else $error("bit timer overran");

  c_break_done: cover property (q.phase == lfl_pkg::P_BRK_DELIM ##1 q.phase == lfl_pkg::P_TX_BYTE);
  c_rx_done: cover property ($rose(q.status[lfl_pkg::ST_RXDONE]));
  c_low_set: cover property ($rose(|q.status[3:0]) ##1 irq);
endmodule

// ### lfl_pkg.sv
package lfl_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_FRAME  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CLEAR  = 8'h0C;
  localparam logic [7:0] OFF_IEN    = 8'h10;
  localparam logic [7:0] OFF_MIRROR = 8'h14;
  localparam logic [7:0] OFF_BAUD   = 8'h18;
  localparam logic [7:0] OFF_CMD    = 8'h1C;
  localparam logic [7:0] OFF_TXD0   = 8'h20;
  localparam logic [7:0] OFF_TXD1   = 8'h24;
  localparam logic [7:0] OFF_RXD0   = 8'h28;
  localparam logic [7:0] OFF_RXD1   = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ST_TXDONE      = 4;
  localparam int          ST_RXDONE      = 5;
  localparam int          ST_ERR         = 6;
  localparam int          ST_BUSY        = 7;
  localparam int          CMD_SEND       = 0;
  localparam int          CMD_RECV       = 1;
  localparam logic [15:0] BAUD_RST       = 16'h1458;
  localparam logic [3:0]  MODE_RST       = 4'h0;
  localparam logic [6:0]  IEN_RST        = 7'h00;

  // ----------------------------------------------------------------
  // Timing counts in bit times, and the response byte limit
  // ----------------------------------------------------------------
  localparam logic [4:0]  BRK_LOW_BASE   = 5'h0D;
  localparam logic [4:0]  BRK_DELIM_BASE = 5'h01;
  localparam logic [3:0]  MAX_BYTES      = 4'h8;
  localparam logic [3:0]  UART_LAST      = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    P_IDLE, P_BRK_LOW, P_BRK_DELIM, P_TX_BYTE, P_TX_GAP, P_RX_BYTE
  } lfl_phase_t;

  typedef enum logic [1:0] {E_IDLE, E_TX, E_RX} lfl_eng_t;

  // Frame control word, bits 15:0 of the frame register
  typedef struct packed {
    logic [1:0] gap_len;
    logic [1:0] rsv_hi;
    logic [3:0] response_byte_count;
    logic [1:0] rsv_lo;
    logic [1:0] break_delimiter_length;
    logic [3:0] break_low_length;
  } lfl_frame_cfg_t;
endpackage

// ### lfl_low_detect.sv
`timescale 1ns/1ns
module lfl_low_detect (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic cen,
  // Pin and control
  input  wire logic rx_pin,
  input  wire logic enable,
  // Detection results
  output logic      event_pulse,
  output logic      rx_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic en_q;
    logic ev;
  } lfl_ld_st_t;

  localparam lfl_ld_st_t LD_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, en_q: 1'b0, ev: 1'b0};

  lfl_ld_st_t q;
  lfl_ld_st_t d;

  // Synchronise the pin, then look for a fall or an enable onto a low line
  always_comb
  begin
    d = q;
    d.s1 = rx_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.en_q = enable;
    d.ev = enable && ((q.s3 && !q.s2) || (!q.en_q && !q.s2));
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      q <= LD_RST;
    else if (cen)
      q <= d;
  end

  assign event_pulse = q.ev;
  assign rx_level    = q.s2;

  // Checks
  a_edge_event: assert property (@(posedge ref_clk) disable iff (srst)
    cen && enable && q.s3 && !q.s2 |=> q.ev) else $error("falling edge not reported");
  a_enable_low: assert property (@(posedge ref_clk) disable iff (srst)
    cen && enable && !q.en_q && !q.s2 |=> q.ev) else $error("enable on low line missed");
endmodule

// ### lfl_byte_engine.sv
`timescale 1ns/1ns
module lfl_byte_engine (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        cen,
  input  wire logic [15:0] baud,
  // Transmit side
  input  wire logic        tx_go,
  input  wire logic [7:0]  tx_byte,
  output logic             tx_pin,
  output logic             tx_done,
  // Receive side
  input  wire logic        rx_arm,
  input  wire logic        rx_in,
  output logic             rx_done,
  output logic [7:0]       rx_byte,
  output logic             err
);
  typedef struct packed {
    lfl_pkg::lfl_eng_t st;
    logic [15:0]       tmr;
    logic [3:0]        bit_no;
    logic [9:0]        shf;
    logic              tx_pin;
    logic              tx_done;
    logic              rx_done;
    logic [7:0]        rx_byte;
    logic              err;
  } lfl_eng_st_t;

  localparam lfl_eng_st_t ENG_RST = '{st: lfl_pkg::E_IDLE, tx_pin: 1'b1, default: '0};

  lfl_eng_st_t q;
  lfl_eng_st_t d;
  logic        tick;
  logic        mid;

  // Start, eight data bits LSB first, stop; samples taken mid-bit
  always_comb
  begin
    d = q;
    d.tx_done = 1'b0;
    d.rx_done = 1'b0;
    d.err = 1'b0;
    tick = q.tmr >= baud - 16'h0001;
    mid = q.tmr == (baud >> 1);
    d.tmr = tick ? 16'h0000 : q.tmr + 16'h0001;
    unique case (q.st)
      lfl_pkg::E_IDLE:
      begin
        d.tmr = 16'h0000;
        d.bit_no = 4'h0;
        if (tx_go)
        begin
          d.st = lfl_pkg::E_TX;
          d.shf = {1'b1, tx_byte, 1'b0};
          d.tx_pin = 1'b0;
        end
        else if (rx_arm && !rx_in)
          d.st = lfl_pkg::E_RX;
      end
      lfl_pkg::E_TX:
      begin
        // Read back the bus; a mismatch is a bit error
        if (mid && rx_in != q.tx_pin)
        begin
          d.err = 1'b1;
          d.st = lfl_pkg::E_IDLE;
          d.tx_pin = 1'b1;
        end
        else if (tick)
        begin
          if (q.bit_no == lfl_pkg::UART_LAST)
          begin
            d.st = lfl_pkg::E_IDLE;
            d.tx_done = 1'b1;
          end
          else
          begin
            d.bit_no = q.bit_no + 4'h1;
            d.shf = {1'b1, q.shf[9:1]};
            d.tx_pin = q.shf[1];
          end
        end
      end
      lfl_pkg::E_RX:
      begin
        if (!rx_arm)
          d.st = lfl_pkg::E_IDLE;
        else if (mid)
        begin
          if (q.bit_no == 4'h0 && rx_in)
            d.st = lfl_pkg::E_IDLE; // Glitch, not a start bit
          else if (q.bit_no == lfl_pkg::UART_LAST)
          begin
            d.st = lfl_pkg::E_IDLE;
            d.err = !rx_in;
            d.rx_done = rx_in;
            d.rx_byte = q.shf[9:2];
          end
          else if (q.bit_no != 4'h0)
            d.shf = {rx_in, q.shf[9:1]};
        end
        if (tick)
          d.bit_no = q.bit_no + 4'h1;
      end
      default:
        d.st = lfl_pkg::E_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      q <= ENG_RST;
    else if (cen)
      q <= d;
  end

  assign tx_pin  = q.tx_pin;
  assign tx_done = q.tx_done;
  assign rx_done = q.rx_done;
  assign rx_byte = q.rx_byte;
  assign err     = q.err;
endmodule

// ### lfl_lin_node.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// LIN bus as the block sees it: our transmitter plus remote nodes
// ----------------------------------------------------------------
module lfl_lin_node (
  // Bus drivers
  input  wire logic       tx_line,
  input  wire logic [3:0] remote_low,
  // Receive lines back to the block
  output logic [3:0]      rx_line
);
  // Dominant low wins; a released line rests high through the bus pull-up
  assign rx_line = {~remote_low[3:1], tx_line & ~remote_low[0]};
endmodule

// ### lfl_frame_low_detect_tb_top.sv
`timescale 1ns/1ns
module lfl_frame_low_detect_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk    = 1'b0;
  logic        srst       = 1'b1;
  logic        cen        = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  remote_low = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  rx_line;
  logic        tx_line;
  logic        irq;
  logic [31:0] rd;
  logic        rerr;
  int          err_total  = 0;
  int          n_tests    = 0;
  int          n;

  // Clock
  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Block and bus model
  // ----------------------------------------------------------------
  lfl_frame_low_detect lfl_frame_low_detect_i (
    .ref_clk(ref_clk), .srst(srst), .cen(cen), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_receive_pin(rx_line),
    .bus_transmit_pin(tx_line), .irq(irq)
  );

  lfl_lin_node lfl_lin_node_i (
    .tx_line(tx_line), .remote_low(remote_low), .rx_line(rx_line)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bail(input string what);
    err_total++;
    $display("[FAIL] %0t %s timed out", $time, what);
    conclude();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
      if (k > 20) bail("ready");
    end
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Poll the status register until a bit is set
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, lfl_pkg::OFF_STATUS, 32'h0);
      k++;
      if (k > 600) bail("status");
    end
    while (rd[b] !== 1'b1);
  endtask

  // Count cycles the transmit line stays at lvl, one cycle already seen
  task automatic meas(input logic lvl, output int cnt);
    cnt = 1;
    @(posedge ref_clk);
    while (tx_line === lvl)
    begin
      cnt++;
      if (cnt > 2000) bail("line");
      @(posedge ref_clk);
    end
  endtask

  // Remote node sends start, eight data bits LSB first, stop; 16 cycles a bit
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] bits;
    bits = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      remote_low[0] <= ~bits[i];
      repeat (16) @(posedge ref_clk);
    end
    remote_low[0] <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(lfl_pkg::OFF_BAUD, {16'h0, lfl_pkg::BAUD_RST}, "baud reset");
    rd_chk(lfl_pkg::OFF_STATUS, 32'h0, "status reset");
    apb(1'b0, 8'hF0, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped");
    // Low detection, gating and software clear
    apb(1'b1, lfl_pkg::OFF_MODE, 32'hF);
    apb(1'b1, lfl_pkg::OFF_IEN, 32'hF);
    remote_low <= 4'h2;
    wait_bit(1);
    rd_chk(lfl_pkg::OFF_MIRROR, 32'h2, "mirror ch1");
    chk({31'h0, irq}, 32'h1, "irq on low");
    remote_low <= 4'h6;
    repeat (10) @(posedge ref_clk);
    rd_chk(lfl_pkg::OFF_STATUS, 32'h2, "second low gated");
    apb(1'b1, lfl_pkg::OFF_STATUS, 32'hFFFFFFFF);
    rd_chk(lfl_pkg::OFF_STATUS, 32'h2, "write one kept");
    apb(1'b1, lfl_pkg::OFF_STATUS, 32'hFFFFFFFD);
    rd_chk(lfl_pkg::OFF_STATUS, 32'h0, "zero clears");
    chk({31'h0, irq}, 32'h0, "irq drops");
    // Enable written while the line is already low
    apb(1'b1, lfl_pkg::OFF_MODE, 32'h0);
    remote_low <= 4'h8;
    repeat (10) @(posedge ref_clk);
    apb(1'b1, lfl_pkg::OFF_MODE, 32'h8);
    wait_bit(3);
    rd_chk(lfl_pkg::OFF_MIRROR, 32'h8, "mirror ch3");
    apb(1'b1, lfl_pkg::OFF_IEN, 32'h0);
    rd_chk(lfl_pkg::OFF_STATUS, 32'h8, "flag stays");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, lfl_pkg::OFF_CLEAR, 32'h8);
    rd_chk(lfl_pkg::OFF_STATUS, 32'h0, "w1c clear");
    apb(1'b1, lfl_pkg::OFF_MODE, 32'h0);
    remote_low <= 4'h0;
    // Break lengths at both ends of their fields
    apb(1'b1, lfl_pkg::OFF_BAUD, 32'd16);
    apb(1'b1, lfl_pkg::OFF_TXD0, 32'h000055A5);
    for (int c = 0; c < 2; c++)
    begin
      apb(1'b1, lfl_pkg::OFF_FRAME, (c != 0) ? 32'h0000423F : 32'h00000100);
      apb(1'b1, lfl_pkg::OFF_CMD, 32'h1);
      n = 0;
      while (tx_line !== 1'b0)
      begin
        @(posedge ref_clk);
        n++;
        if (n > 50) bail("break");
      end
      meas(1'b0, n);
      chk(n, (c != 0) ? 28 * 16 : 13 * 16, "break low");
      meas(1'b1, n);
      // Two more cycles pass before the byte engine puts the start bit on the line
      chk(n, (c != 0) ? 4 * 16 + 2 : 16 + 2, "delimiter");
      wait_bit(lfl_pkg::ST_TXDONE);
      chk(rd & 32'h40, 32'h0, "tx error");
      apb(1'b1, lfl_pkg::OFF_STATUS, 32'h0);
    end
    // Readback broken by a remote node holding the line low
    apb(1'b1, lfl_pkg::OFF_FRAME, 32'h00000100);
    apb(1'b1, lfl_pkg::OFF_CMD, 32'h1);
    remote_low <= 4'h1;
    wait_bit(lfl_pkg::ST_ERR);
    remote_low <= 4'h0;
    repeat (40) @(posedge ref_clk);
    chk({31'h0, tx_line}, 32'h1, "line after error");
    apb(1'b1, lfl_pkg::OFF_STATUS, 32'h0);
    // Reception: good stop bit, then a broken one
    for (int c = 0; c < 2; c++)
    begin
      apb(1'b1, lfl_pkg::OFF_CMD, 32'h2);
      send_byte(8'h96, c == 0);
      wait_bit((c != 0) ? lfl_pkg::ST_ERR : lfl_pkg::ST_RXDONE);
      chk(rd & 32'h60, (c != 0) ? 32'h40 : 32'h20, "rx status");
      apb(1'b0, lfl_pkg::OFF_RXD0, 32'h0);
      if (c == 0) chk(rd & 32'hFF, 32'h96, "rx byte");
      apb(1'b1, lfl_pkg::OFF_STATUS, 32'h0);
    end
    conclude();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bail("run");
  end
endmodule
